// ### hw/dgc_top.sv
// dual channel gain control logic: parallel, serial and up/down control
`timescale 1ns/100ps
//
// Function
// - mode pins pick parallel (00), serial (01) or up/down (1x) control
// - each channel keeps its own six bit gain code
// - code 0 is top gain, each step 1 dB less, 35 and up floor
// - first 12 dB of cut in amplifier, rest in 0..23 dB attenuator
// - parallel: hold low follows pins, hold high keeps the latched code
// - serial write: select low, sixteen clocks, bits shifted in MSB first
// - word holds gain, quick step select, read flag and seven ignored bits
// - both selects low writes the same word to both channels
// - one shared data line, so channels are read back one at a time
// - quick attenuate pin high cuts 2, 4, 8 or 16 dB per select bits
// - up/down pulse raises gain when direction low, lowers when high
// - direction differing between rising and falling edge means reset
// - an up/down reset forces code 111111
// - step size pins give 1, 2, 4 or 8 dB steps
// - up/down count rails at both ends, never wraps
// - channel active while its power-up pin is high, asleep when low
// - performance pin picks high performance or low power operation
// - control pins change meaning with the selected interface
// - one read frame only after a write with read flag set
// - read data changes on each serial clock rising edge
// - quick attenuate acts only in serial mode
module dgc_top
    import dgc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic iface_select_hi,
    input wire logic iface_select_lo,
    input wire logic perf_select,
    input wire logic chan_a_power_up,
    input wire logic chan_b_power_up,
    input wire logic chan_a_hold,
    input wire logic chan_b_hold,
    input wire logic [5:0] chan_a_gain_inputs,
    input wire logic [5:0] chan_b_gain_inputs,
    input wire logic step_size_sel_hi,
    input wire logic step_size_sel_lo,
    input wire logic spi_sclk,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    output dgc_chan_out_t chan_a_out,
    output dgc_chan_out_t chan_b_out,
    output logic chan_a_active,
    output logic chan_b_active,
    output logic high_perf,
    output dgc_mode_t active_mode
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_W = 23;

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;

    assign raw = {iface_select_hi, iface_select_lo, perf_select,
                  chan_a_power_up, chan_b_power_up,
                  chan_a_hold, chan_b_hold,
                  chan_a_gain_inputs, chan_b_gain_inputs,
                  step_size_sel_hi, step_size_sel_lo,
                  spi_sclk, sdio_i};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    logic [1:0] mode_pins;
    logic perf_s;
    logic [1:0] pwr_s;
    logic [1:0] hold_s;
    logic [5:0] pins_s [0:1];
    logic [1:0] gs_s;
    logic sclk_s;
    logic sdio_s;

    assign mode_pins = sync_q[22:21];
    assign perf_s = sync_q[20];
    assign pwr_s = {sync_q[18], sync_q[19]};
    assign hold_s = {sync_q[16], sync_q[17]};
    assign pins_s[0] = sync_q[15:10];
    assign pins_s[1] = sync_q[9:4];
    assign gs_s = sync_q[3:2];
    assign sclk_s = sync_q[1];
    assign sdio_s = sync_q[0];

    // ------------------------------------------------------------------
    // interface selection
    // ------------------------------------------------------------------
    dgc_mode_t mode;

    always_comb begin
        case (mode_pins)
            2'b00: mode = DGC_MODE_PAR;
            2'b01: mode = DGC_MODE_SPI;
            default: mode = DGC_MODE_UPDN;
        endcase
    end

    logic is_par;
    logic is_spi;
    logic is_updn;

    assign is_par = (mode == DGC_MODE_PAR);
    assign is_spi = (mode == DGC_MODE_SPI);
    assign is_updn = (mode == DGC_MODE_UPDN);

    // the same six pins carry gain bits, selects or step controls
    logic [1:0] sel_now;
    logic [1:0] quick_pin;
    logic [1:0] dir_pin;
    logic [1:0] stepclk_pin;

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            sel_now[ch] = is_spi & ~pins_s[ch][DGC_PIN_SEL_N];
            quick_pin[ch] = is_spi & pins_s[ch][DGC_PIN_QUICK];
            dir_pin[ch] = pins_s[ch][DGC_PIN_DIR];
            stepclk_pin[ch] = is_updn & pins_s[ch][DGC_PIN_STEP_CLK];
        end
    end

    // ------------------------------------------------------------------
    // parallel latch
    // ------------------------------------------------------------------
    logic [5:0] par_q [0:1];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            par_q[0] <= DGC_GAIN_RESET_CODE;
            par_q[1] <= DGC_GAIN_RESET_CODE;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (is_par && !hold_s[ch]) begin
                    par_q[ch] <= pins_s[ch];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------------
    dgc_spi_state_t spi_q;
    logic [15:0] word_q [0:1];
    logic [15:0] shift_q;
    logic [4:0] cnt_q;
    logic [1:0] sel_q;
    logic [1:0] rd_arm_q;
    logic rd_ch_q;
    logic sclk_prev_q;
    logic sclk_rise;
    logic frame;
    logic one_sel;
    logic one_ch;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign frame = |sel_now;
    assign one_sel = sel_now[0] ^ sel_now[1];
    assign one_ch = sel_now[1];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            spi_q <= DGC_SPI_IDLE;
            shift_q <= '0;
            cnt_q <= '0;
            sel_q <= '0;
            rd_ch_q <= 1'b0;
            sdio_o <= 1'b0;
            sdio_oe <= 1'b0;
        end else begin
            case (spi_q)
                DGC_SPI_IDLE: begin
                    cnt_q <= '0;
                    sel_q <= sel_now;
                    if (frame && one_sel && rd_arm_q[one_ch]) begin
                        spi_q <= DGC_SPI_READ;
                        rd_ch_q <= one_ch;
                        shift_q <= word_q[one_ch];
                        sdio_o <= word_q[one_ch][DGC_RW_POS];
                        sdio_oe <= 1'b1;
                    end else if (frame) begin
                        spi_q <= DGC_SPI_WRITE;
                    end
                end
                DGC_SPI_WRITE: begin
                    if (!frame) begin
                        spi_q <= DGC_SPI_IDLE;
                    end else if (sclk_rise) begin
                        shift_q <= {shift_q[14:0], sdio_s};
                        if (cnt_q != DGC_CNT_SAT) begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                end
                DGC_SPI_READ: begin
                    if (!frame) begin
                        spi_q <= DGC_SPI_IDLE;
                        sdio_oe <= 1'b0;
                    end else if (sclk_rise) begin
                        shift_q <= {shift_q[14:0], 1'b0};
                        sdio_o <= shift_q[14];
                    end
                end
                default: begin
                    spi_q <= DGC_SPI_IDLE;
                    sdio_oe <= 1'b0;
                end
            endcase
        end
    end

    // a frame of exactly sixteen clocks commits at select release
    logic commit;

    assign commit = (spi_q == DGC_SPI_WRITE) && !frame && is_spi
                    && (cnt_q == DGC_WORD_BITS);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            word_q[0] <= DGC_WORD_RESET;
            word_q[1] <= DGC_WORD_RESET;
            rd_arm_q <= '0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (commit && sel_q[ch]) begin
                    word_q[ch] <= shift_q;
                    rd_arm_q[ch] <= shift_q[DGC_RW_POS];
                end else if (spi_q == DGC_SPI_READ && !frame
                             && rd_ch_q == ch[0]) begin
                    rd_arm_q[ch] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // up/down counters
    // ------------------------------------------------------------------
    logic [5:0] updn_gain [0:1];
    logic [5:0] updn_step;

    assign updn_step = dgc_updn_step(gs_s);

    for (genvar g = 0; g < 2; g++) begin : g_updn
        dgc_updn u_updn (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .enable(is_updn),
            .step_direction(dir_pin[g]),
            .step_clock(stepclk_pin[g]),
            .step_db(updn_step),
            .gain_q(updn_gain[g])
        );
    end

    // ------------------------------------------------------------------
    // gain decode
    // ------------------------------------------------------------------
    function automatic dgc_chan_out_t dgc_decode(input logic [5:0] code,
                                                 input logic [5:0] extra);
        logic [6:0] cut;
        logic [6:0] amp;
        logic [6:0] att;
        cut = {1'b0, code};
        if (cut > DGC_TOTAL_CUT_DB) begin
            cut = DGC_TOTAL_CUT_DB;
        end
        cut = cut + {1'b0, extra};
        if (cut > DGC_TOTAL_CUT_DB) begin
            cut = DGC_TOTAL_CUT_DB;
        end
        amp = (cut > DGC_AMP_CUT_DB) ? DGC_AMP_CUT_DB : cut;
        att = cut - amp;
        if (att > DGC_ATTEN_MAX_DB) begin
            att = DGC_ATTEN_MAX_DB;
        end
        dgc_decode.gain_code = code;
        dgc_decode.amp_cut_db = amp[3:0];
        dgc_decode.atten_db = att[4:0];
    endfunction : dgc_decode

    logic [5:0] code_sel [0:1];
    logic [5:0] quick_db [0:1];

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            case (mode)
                DGC_MODE_PAR: code_sel[ch] = par_q[ch];
                DGC_MODE_SPI: code_sel[ch] =
                    word_q[ch][DGC_GAIN_HI_POS:DGC_GAIN_LO_POS];
                default: code_sel[ch] = updn_gain[ch];
            endcase
            if (quick_pin[ch]) begin
                quick_db[ch] = dgc_quick_step(
                    word_q[ch][DGC_FA_HI_POS:DGC_FA_LO_POS]);
            end else begin
                quick_db[ch] = 6'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chan_a_out <= '0;
            chan_b_out <= '0;
        end else begin
            chan_a_out <= dgc_decode(code_sel[0], quick_db[0]);
            chan_b_out <= dgc_decode(code_sel[1], quick_db[1]);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chan_a_active <= 1'b0;
            chan_b_active <= 1'b0;
            high_perf <= 1'b0;
            active_mode <= DGC_MODE_PAR;
        end else begin
            chan_a_active <= pwr_s[0];
            chan_b_active <= pwr_s[1];
            high_perf <= perf_s;
            active_mode <= mode;
        end
    end

endmodule : dgc_top

// ### hw/dgc_updn.sv
// one channel of the up/down step counter
`timescale 1ns/100ps
module dgc_updn
    import dgc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic step_direction,
    input wire logic step_clock,
    input wire logic [5:0] step_db,
    output logic [5:0] gain_q
);

    logic clk_prev_q;
    logic dir_at_rise_q;
    logic armed_q;
    logic rise;
    logic fall;
    logic [6:0] sum;

    assign rise = step_clock & ~clk_prev_q;
    assign fall = ~step_clock & clk_prev_q;
    assign sum = {1'b0, gain_q} + {1'b0, step_db};

    // ------------------------------------------------------------------
    // edge tracking
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= step_clock;
        end
    end

    // direction caught on the rising edge, a pulse counts only once armed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dir_at_rise_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (!enable) begin
            armed_q <= 1'b0;
        end else if (rise) begin
            dir_at_rise_q <= step_direction;
            armed_q <= 1'b1;
        end else if (fall) begin
            armed_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gain_q <= DGC_GAIN_RESET_CODE;
        end else if (enable && armed_q && fall) begin
            if (step_direction != dir_at_rise_q) begin
                gain_q <= DGC_GAIN_RESET_CODE;
            end else if (!step_direction) begin
                // more gain is a smaller code
                if (gain_q > step_db) begin
                    gain_q <= gain_q - step_db;
                end else begin
                    gain_q <= DGC_GAIN_MAX_CODE;
                end
            end else if (sum > DGC_CODE_CEIL) begin
                gain_q <= DGC_GAIN_RESET_CODE;
            end else begin
                gain_q <= sum[5:0];
            end
        end
    end

endmodule : dgc_updn

// ### pkg/dgc_pkg.sv
// shared constants, types and helpers for the dual gain control block
package dgc_pkg;

    // ------------------------------------------------------------------
    // gain code range
    // ------------------------------------------------------------------
    localparam logic [5:0] DGC_GAIN_MAX_CODE = 6'h00;
    localparam logic [5:0] DGC_GAIN_FLOOR_CODE = 6'h23;
    localparam logic [5:0] DGC_GAIN_RESET_CODE = 6'h3f;
    localparam logic [6:0] DGC_CODE_CEIL = 7'h3f;
    localparam logic [6:0] DGC_TOTAL_CUT_DB = 7'h23;
    localparam logic [6:0] DGC_AMP_CUT_DB = 7'h0c;
    localparam logic [6:0] DGC_ATTEN_MAX_DB = 7'h17;

    // ------------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------------
    localparam int unsigned DGC_WORD_W = 16;
    localparam logic [4:0] DGC_WORD_BITS = 5'h10;
    localparam logic [4:0] DGC_CNT_SAT = 5'h1f;
    localparam int unsigned DGC_RW_POS = 15;
    localparam int unsigned DGC_FA_HI_POS = 7;
    localparam int unsigned DGC_FA_LO_POS = 6;
    localparam int unsigned DGC_GAIN_HI_POS = 5;
    localparam int unsigned DGC_GAIN_LO_POS = 0;
    localparam logic [15:0] DGC_WORD_RESET = 16'h003f;

    // ------------------------------------------------------------------
    // shared pin positions within a channel's six gain pins
    // ------------------------------------------------------------------
    localparam int unsigned DGC_PIN_DIR = 0;
    localparam int unsigned DGC_PIN_STEP_CLK = 1;
    localparam int unsigned DGC_PIN_QUICK = 2;
    localparam int unsigned DGC_PIN_SEL_N = 3;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DGC_MODE_PAR = 2'b00,
        DGC_MODE_SPI = 2'b01,
        DGC_MODE_UPDN = 2'b10
    } dgc_mode_t;

    typedef enum logic [1:0] {
        DGC_SPI_IDLE = 2'b00,
        DGC_SPI_WRITE = 2'b01,
        DGC_SPI_READ = 2'b10
    } dgc_spi_state_t;

    typedef struct packed {
        logic [5:0] gain_code;
        logic [3:0] amp_cut_db;
        logic [4:0] atten_db;
    } dgc_chan_out_t;

    // ------------------------------------------------------------------
    // step size helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] dgc_updn_step(input logic [1:0] sel);
        case (sel)
            2'b00: dgc_updn_step = 6'h01;
            2'b01: dgc_updn_step = 6'h02;
            2'b10: dgc_updn_step = 6'h04;
            default: dgc_updn_step = 6'h08;
        endcase
    endfunction : dgc_updn_step

    function automatic logic [5:0] dgc_quick_step(input logic [1:0] sel);
        case (sel)
            2'b00: dgc_quick_step = 6'h02;
            2'b01: dgc_quick_step = 6'h04;
            2'b10: dgc_quick_step = 6'h08;
            default: dgc_quick_step = 6'h10;
        endcase
    endfunction : dgc_quick_step

endpackage : dgc_pkg

// ### verification/dgc_host_model.sv
// serial host model: select, clock and data pins
`timescale 1ns/100ps
module dgc_host_model (
    input wire logic sys_clk,
    input wire logic sdio,
    output logic sclk,
    output logic sel_a_n,
    output logic sel_b_n,
    output logic sd_d,
    output logic sd_oe
);
    initial begin
        sclk = 1'b0;
        {sel_a_n, sel_b_n} = 2'b11;
        sd_d = 1'b0;
        sd_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    // n pulses, sel bit0 a bit1 b; rd leaves the data line to the device
    task automatic frame(input logic [1:0] sel, input logic [15:0] w,
            input int n, input logic rd, output logic [15:0] q);
        q = 16'h0000;
        {sel_b_n, sel_a_n} = ~sel;
        sd_oe = !rd;
        tick(8);
        q[15] = sdio;
        for (int i = 0; i < n; i++) begin
            sd_d = w[15 - i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
            if (i < 15)
                q[14 - i] = sdio;
        end
        tick(4);
        {sel_a_n, sel_b_n} = 2'b11;
        sd_oe = 1'b0;
        tick(8);
    endtask : frame
endmodule : dgc_host_model

// ### verification/dgc_top_asserts.sv
// port checks for the dual gain control top
`timescale 1ns/100ps
module dgc_top_asserts
    import dgc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic iface_select_hi,
    input wire logic iface_select_lo,
    input wire logic perf_select,
    input wire logic chan_a_power_up,
    input wire logic chan_b_power_up,
    input wire logic chan_a_hold,
    input wire logic [5:0] chan_a_gain_inputs,
    input wire dgc_chan_out_t chan_a_out,
    input wire logic chan_a_active,
    input wire logic chan_b_active,
    input wire logic high_perf,
    input wire logic sdio_oe,
    input wire dgc_mode_t active_mode
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    wire logic par_on = !iface_select_hi && !iface_select_lo &&
        active_mode == DGC_MODE_PAR;

    sequence pins_steady;
        $stable({iface_select_hi, iface_select_lo}) [*5];
    endsequence
    sequence held_a;
        (par_on && chan_a_hold) [*5];
    endsequence
    sequence open_a;
        (par_on && !chan_a_hold && $stable(chan_a_gain_inputs)) [*5];
    endsequence
    sequence updn_run;
        (active_mode == DGC_MODE_UPDN) [*3];
    endsequence

    AST_MODE: assert property (
        pins_steady |-> active_mode == (iface_select_hi ? DGC_MODE_UPDN :
            (iface_select_lo ? DGC_MODE_SPI : DGC_MODE_PAR)))
        else $error("interface mode does not follow select pins");
    AST_PERF: assert property (
        $stable(perf_select) [*5] |-> high_perf == perf_select)
        else $error("performance output does not follow its pin");
    AST_PWR: assert property (
        $stable({chan_a_power_up, chan_b_power_up}) [*5] |->
            {chan_a_active, chan_b_active} ==
            {chan_a_power_up, chan_b_power_up})
        else $error("channel active flags do not follow power pins");
    AST_HOLD: assert property (
        held_a |=> $stable(chan_a_out.gain_code))
        else $error("held gain code changed");
    AST_FOLLOW: assert property (
        open_a |-> chan_a_out.gain_code == chan_a_gain_inputs)
        else $error("open latch gain code does not follow pins");
    AST_SPLIT: assert property (
        chan_a_out.atten_db != 5'h00 |-> chan_a_out.amp_cut_db == 4'hc)
        else $error("attenuator used before amplifier cut is full");
    AST_OE: assert property (
        sdio_oe |-> active_mode == DGC_MODE_SPI)
        else $error("data line driven outside serial mode");
    AST_RAIL: assert property (
        updn_run ##0 $past(chan_a_out.gain_code) == 6'h3f |->
            chan_a_out.gain_code >= 6'h37)
        else $error("step count wrapped past the minimum gain end");
endmodule : dgc_top_asserts

bind dgc_top dgc_top_asserts u_chk (
    .sys_clk, .rstn, .iface_select_hi, .iface_select_lo, .perf_select,
    .chan_a_power_up, .chan_b_power_up, .chan_a_hold, .chan_a_gain_inputs,
    .chan_a_out, .chan_a_active, .chan_b_active, .high_perf, .sdio_oe,
    .active_mode
);

// ### verification/dgc_top_tb.sv
// self-checking bench for the dual gain control block
`timescale 1ns/100ps
module dgc_top_tb;
    import dgc_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn, iface_select_hi, iface_select_lo, perf_select, d;
    logic chan_a_power_up, chan_b_power_up, chan_a_hold, chan_b_hold;
    logic step_size_sel_hi, step_size_sel_lo;
    logic flip = 1'b0;
    logic [5:0] pa, pb, e, ca, cb, s;
    logic [2:0] px, pw;
    logic [15:0] w, q;
    wire logic spi_sclk, sel_a_n, sel_b_n, h_d, h_oe, sdio_o, sdio_oe;
    wire logic sdio_w, spi_on;
    wire logic [5:0] chan_a_gain_inputs, chan_b_gain_inputs;
    dgc_chan_out_t chan_a_out, chan_b_out;
    logic chan_a_active, chan_b_active, high_perf;
    dgc_mode_t active_mode;
    int bad_count = 0;
    int checked = 0;
    int seed;
    int oe_cnt = 0;
    int oe_mark;

    assign spi_on = !iface_select_hi && iface_select_lo;
    assign chan_a_gain_inputs = spi_on ? {pa[5:4], sel_a_n, pa[2:0]} : pa;
    assign chan_b_gain_inputs = spi_on ? {pb[5:4], sel_b_n, pb[2:0]} : pb;
    // a released data line keeps changing instead of holding its last bit
    assign sdio_w = sdio_oe ? sdio_o : (h_oe ? h_d : flip);
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) flip <= ~flip;
    always @(posedge sys_clk) if (sdio_oe === 1'b1) oe_cnt <= oe_cnt + 1;

    dgc_top u_dut (
        .sys_clk, .rstn, .iface_select_hi, .iface_select_lo, .perf_select,
        .chan_a_power_up, .chan_b_power_up, .chan_a_hold, .chan_b_hold,
        .chan_a_gain_inputs, .chan_b_gain_inputs, .step_size_sel_hi,
        .step_size_sel_lo, .spi_sclk, .sdio_i(sdio_w), .sdio_o, .sdio_oe,
        .chan_a_out, .chan_b_out, .chan_a_active, .chan_b_active,
        .high_perf, .active_mode
    );
    dgc_host_model u_host (
        .sys_clk, .sdio(sdio_w), .sclk(spi_sclk), .sel_a_n, .sel_b_n,
        .sd_d(h_d), .sd_oe(h_oe)
    );

    function automatic dgc_chan_out_t exp_out(input logic [5:0] c,
            input logic [6:0] qk);
        logic [6:0] cut;
        cut = ((c > 6'h23) ? 7'h23 : {1'b0, c}) + qk;
        if (cut > 7'h23)
            cut = 7'h23;
        exp_out.gain_code = c;
        exp_out.amp_cut_db = (cut > 7'h0c) ? 4'hc : cut[3:0];
        exp_out.atten_db = (cut > 7'h0c) ? 5'(cut - 7'h0c) : 5'h00;
    endfunction : exp_out

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic chk_out(input logic [5:0] ga, input logic [6:0] qa,
            input logic [5:0] gb);
        chk({1'b0, chan_a_out}, {1'b0, exp_out(ga, qa)});
        chk({1'b0, chan_b_out}, {1'b0, exp_out(gb, 7'h00)});
    endtask : chk_out
    // up/down pulse: d0 at the rising edge, d1 at the falling edge
    task automatic pulse(input logic d0, input logic d1);
        pa[0] = d0;
        wt(5);
        pa[1] = 1'b1;
        wt(5);
        pa[0] = d1;
        wt(5);
        pa[1] = 1'b0;
        wt(5);
    endtask : pulse
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        bad_count++;
        complete_run();
    end

    initial begin
        {rstn, iface_select_hi, iface_select_lo, perf_select} = 4'h0;
        {chan_a_power_up, chan_b_power_up, chan_a_hold, chan_b_hold} = 4'h0;
        {step_size_sel_hi, step_size_sel_lo} = 2'b00;
        pa = 6'h00;
        pb = 6'h00;
        seed = $urandom(32'h9a18c7c1);
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        wt(4);
        for (int m = 0; m < 4; m++) begin
            {iface_select_hi, iface_select_lo} = 2'(m);
            wt(6);
            chk(16'(active_mode), (m > 1) ? 16'h2 : 16'(m));
        end
        {iface_select_hi, iface_select_lo} = 2'b00;
        for (int i = 0; i < 12; i++) begin
            pa = (i == 0) ? 6'h23 : (i == 1) ? 6'h0c : 6'($urandom);
            pb = (i == 2) ? 6'h3f : 6'($urandom);
            {chan_a_hold, chan_b_hold} = 2'b00;
            wt(6);
            chk_out(pa, 7'h00, pb);
            ca = pa;
            cb = pb;
            chan_a_hold = 1'b1;
            chan_b_hold = 1'(i);
            wt(4);
            pa = ~pa;
            pb = 6'($urandom);
            wt(6);
            chk_out(ca, 7'h00, chan_b_hold ? cb : pb);
        end
        {chan_a_hold, chan_b_hold} = 2'b00;
        repeat (6) begin
            px = 3'($urandom);
            {perf_select, chan_a_power_up, chan_b_power_up} = px;
            wt(6);
            pw = {high_perf, chan_a_active, chan_b_active};
            chk(16'(pw), 16'(px));
        end
        {iface_select_hi, iface_select_lo} = 2'b01;
        pa = 6'h00;
        pb = 6'h00;
        wt(6);
        e = 6'h3f;
        chk_out(e, 7'h00, e);
        for (int k = 0; k < 4; k++) begin
            w = {1'b0, 7'($urandom), 2'(k), 6'($urandom)};
            u_host.frame(2'b01, w, 16, 1'b0, q);
            pa[2] = 1'b1;
            wt(6);
            chk_out(w[5:0], 7'(2 << k), e);
            pa[2] = 1'b0;
            wt(6);
            chk_out(w[5:0], 7'h00, e);
        end
        w = {9'h000, 7'($urandom)};
        u_host.frame(2'b11, w, 16, 1'b0, q);
        chk_out(w[5:0], 7'h00, w[5:0]);
        ca = w[5:0];
        w = {1'b0, 15'($urandom)};
        u_host.frame(2'b01, w, 15, 1'b0, q);
        chk_out(ca, 7'h00, ca);
        w = {1'b1, 7'h00, 8'($urandom)};
        u_host.frame(2'b01, w, 16, 1'b0, q);
        u_host.frame(2'b01, 16'h0000, 16, 1'b1, q);
        chk(q, w);
        chk(16'(oe_cnt != 0), 16'h0001);
        oe_mark = oe_cnt;
        u_host.frame(2'b01, 16'h0000, 16, 1'b0, q);
        chk(16'(oe_cnt - oe_mark), 16'h0000);
        {iface_select_hi, iface_select_lo} = 2'b10;
        pa = 6'h00;
        wt(6);
        for (int g = 0; g < 4; g++) begin
            {step_size_sel_hi, step_size_sel_lo} = 2'(g);
            s = 6'h01 << g;
            pulse(1'b0, 1'b1);
            e = 6'h3f;
            chk_out(e, 7'h00, 6'h3f);
            for (int k = 0; k < 15; k++) begin
                d = (k == 0) || (k < 6 && 1'($urandom));
                pulse(d, d);
                if (d)
                    e = (e > 6'h3f - s) ? 6'h3f : e + s;
                else
                    e = (e < s) ? 6'h00 : e - s;
                chk_out(e, 7'h00, 6'h3f);
            end
        end
        complete_run();
    end
endmodule : dgc_top_tb
